// ---- bench/tdmtx_host_model.sv ----
// Host end of the TDM link: bit clock, frame sync and a record of the line.
`timescale 1ns/1ps
`default_nettype none
module tdmtx_host_model
(
  input  wire logic clk,
  output logic      serial_bit_clock,
  output logic      frame_sync,
  input  wire logic serial_data_output,
  input  wire logic serial_data_output_oe_n,
  input  wire logic serial_data_keeper_on
);
  // Line seen early (a) and late (b) in each period: 0/1 driven, 2 open, 3 kept.
  logic [1:0] rec_a [0:255];
  logic [1:0] rec_b [0:255];
  logic [1:0] code;

  // A released line reports as open or kept, never as a stale level.
  assign code = serial_data_output_oe_n ? {1'b1, serial_data_keeper_on}
                                        : {1'b0, serial_data_output};

  // The clock stands still between frames, as a real host may stop it.
  initial
  begin
    serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
  end

  // One frame of 80 ns periods; sync is high at the first rise only.
  task automatic run_frame(input int nbits);
    for (int k = 0; k <= nbits; k++)
    begin
      @(negedge clk);
      serial_bit_clock = 1'b1;
      frame_sync = (k == 0);
      repeat (3) @(negedge clk);
      rec_a[k] = code;
      @(negedge clk);
      serial_bit_clock = 1'b0;
      repeat (3) @(negedge clk);
      rec_b[k] = code;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/tdmtx_slot_formatter_tb.sv ----
// Self-checking bench for the TDM transmit slot formatter.
`include "tdmtx_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tdmtx_slot_formatter_tb;
  localparam int NB = 192;
  logic        clk = 1'b0;
  logic        sys_rst, wr_en, rd_en, bclk, fsync, taken, sdo, oe_n, kon;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] w [1:3];
  logic [7:0]  cfg [0:3];
  logic [7:0]  lf [4] = '{8'h02, 8'h61, 8'hA0, 8'h0F};
  logic [31:0] r;
  int          error_cnt = 0, checked = 0, seed = 83, cyc = 0, takes = 0;
  int          ex [NB];

  tdmtx_slot_formatter #(.SLOT_BITS(32), .WORD_BITS(16)) tdmtx_slot_formatter_i (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .serial_bit_clock(bclk), .frame_sync(fsync),
    .voltage_sense_word(w[1]), .current_sense_word(w[2]), .pulse_density_word(w[3]),
    .sample_taken(taken), .serial_data_output(sdo), .serial_data_output_oe_n(oe_n),
    .serial_data_keeper_on(kon));

  tdmtx_host_model tdmtx_host_model_i (
    .clk(clk), .serial_bit_clock(bclk), .frame_sync(fsync), .serial_data_output(sdo),
    .serial_data_output_oe_n(oe_n), .serial_data_keeper_on(kon));

  // 100 MHz system clock.
  always #5 clk = ~clk;

  // Cycle ceiling cuts a hang short; capture pulses are counted here too.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (taken === 1'b1)
      takes <= takes + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    check("reg_rd_data", e, rdata);
  endtask

  // Expected line per bit cycle; 4 marks a cycle that the previous frame's keeper may own.
  task automatic build();
    int p, src, last;
    int ord [3] = '{2, 1, 3};
    last = -1;
    for (int k = 0; k < NB; k++)
    begin
      p = k - int'(cfg[0][3:1]);
      src = 0;
      foreach (ord[i])
        if (src == 0 && p >= 0 && p % 32 < 16 && cfg[ord[i]][6] && cfg[ord[i]][5:0] == p / 32)
          src = ord[i];
      if (src != 0)
      begin
        ex[k] = ((cfg[0][7] | cfg[0][5]) && p % 32 == 15) ? 2 + int'(cfg[0][5])
                                                           : int'(w[src][15 - p % 32]);
        last = k;
      end
      else if (cfg[0][5])
        ex[k] = (last < 0) ? 4 : (cfg[0][6] || k == last + 1) ? 3 : int'(cfg[0][4]) * 2;
      else
        ex[k] = int'(cfg[0][4]) * 2;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset, register defaults, then random frames checked bit by bit.
  initial
  begin
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    foreach (w[i]) w[i] = 16'h0000;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd(`TDMTX_ADDR_LINE_FMT, `TDMTX_RST_LINE_FMT);
    rd(`TDMTX_ADDR_VS_SLOT, `TDMTX_RST_VS_SLOT);
    rd(`TDMTX_ADDR_IS_SLOT, `TDMTX_RST_IS_SLOT);
    rd(`TDMTX_ADDR_PD_SLOT, `TDMTX_RST_PD_SLOT);
    check("idle oe_n", 8'h01, {7'h00, oe_n});
    check("idle keeper", 8'h00, {7'h00, kon});
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h00);
    $display("register test done");
    for (int f = 0; f < 12; f++)
    begin
      r = $random(seed);
      cfg[0] = (f < 4) ? lf[f] : r[7:0];
      if (f < 4)
        r[13:8] = r[13:8] | 6'h15;
      // Slots rise from current to voltage to PDM.
      cfg[2] = {1'b0, r[8], 5'h00, r[9]};
      cfg[1] = {1'b0, r[10], cfg[2][5:0] + 6'h01 + {5'h00, r[11]}};
      cfg[3] = {1'b0, r[12], cfg[1][5:0] + 6'h01 + {5'h00, r[13]}};
      foreach (w[i]) w[i] = 16'($random(seed));
      for (int i = 0; i < 4; i++)
        wr(`TDMTX_ADDR_LINE_FMT + 8'(i), cfg[i]);
      for (int i = 0; i < 4; i++)
        rd(`TDMTX_ADDR_LINE_FMT + 8'(i), cfg[i]);
      build();
      takes = 0;
      tdmtx_host_model_i.run_frame(NB);
      check("sample_taken", 8'h01, 8'(takes));
      for (int k = 0; k < NB; k++)
        if (ex[k] != 4)
          check("line", 8'(ex[k]), {6'h00, cfg[0][0] ? tdmtx_host_model_i.rec_a[k + 1]
                : tdmtx_host_model_i.rec_b[k]});
      $display("frame %0d done", f);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verilog/tdmtx_defines.svh ----
// Register offsets, field positions, reset values and bit-cycle counter width for the TDM transmit formatter.
`ifndef TDMTX_DEFINES_SVH
`define TDMTX_DEFINES_SVH

`define TDMTX_ADDR_LINE_FMT   8'h0E
`define TDMTX_ADDR_VS_SLOT    8'h0F
`define TDMTX_ADDR_IS_SLOT    8'h10
`define TDMTX_ADDR_PD_SLOT    8'h11

`define TDMTX_RST_LINE_FMT    8'h13
`define TDMTX_RST_VS_SLOT     8'h02
`define TDMTX_RST_IS_SLOT     8'h00
`define TDMTX_RST_PD_SLOT     8'h04

`define TDMTX_BIT_LSB_HALF    7
`define TDMTX_BIT_KEEP_CFG    6
`define TDMTX_BIT_KEEP_EN     5
`define TDMTX_BIT_FILL        4
`define TDMTX_OFS_HI          3
`define TDMTX_OFS_LO          1
`define TDMTX_BIT_EDGE        0
`define TDMTX_BIT_SEND_EN     6
`define TDMTX_SLOT_HI         5
`define TDMTX_SLOT_LO         0

`define TDMTX_CNT_BITS        12

`endif

// ---- verilog/tdmtx_pkg.sv ----
// Types shared by the TDM transmit slot formatter.
package tdmtx_pkg;
  // Which sample source owns the bit being driven.
  typedef enum logic [1:0] {TDMTX_SRC_NONE, TDMTX_SRC_IS, TDMTX_SRC_VS, TDMTX_SRC_PD} tdmtx_src_t;
  // What the output pin is doing in each bit cycle: fill, data or keeper.
  typedef enum logic [1:0] {TDMTX_LN_FILL, TDMTX_LN_DATA, TDMTX_LN_KEEP} tdmtx_line_t;
endpackage

// ---- verilog/tdmtx_slot_formatter.sv ----
// TDM transmit slot formatter: places sense and decimated PDM words into programmable slots.
`include "tdmtx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tdmtx_slot_formatter
  import tdmtx_pkg::*;
#(
  parameter int SLOT_BITS = 32,
  parameter int WORD_BITS = 16
)
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wr_data,
  output logic      [7:0]           reg_rd_data,
  input  wire logic                 serial_bit_clock,
  input  wire logic                 frame_sync,
  input  wire logic [WORD_BITS-1:0] voltage_sense_word,
  input  wire logic [WORD_BITS-1:0] current_sense_word,
  input  wire logic [WORD_BITS-1:0] pulse_density_word,
  output logic                      sample_taken,
  output logic                      serial_data_output,
  output logic                      serial_data_output_oe_n,
  output logic                      serial_data_keeper_on
);

  localparam int SLOT_LOG = $clog2(SLOT_BITS);
  localparam int CNT_W    = `TDMTX_CNT_BITS;

  // The slot index is a plain bit slice, so slots must be a power of two.
  if ((1 << SLOT_LOG) != SLOT_BITS || WORD_BITS < 1 || WORD_BITS > SLOT_BITS || SLOT_LOG > 6)
  begin
    $error("tdmtx_slot_formatter: slot or word length unsupported");
  end

  logic [7:0] line_fmt_q;
  logic [7:0] vs_cfg_q;
  logic [7:0] is_cfg_q;
  logic [7:0] pd_cfg_q;

  // Configuration registers; reserved bit 7 of the slot registers is kept as written.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      line_fmt_q <= `TDMTX_RST_LINE_FMT;
      vs_cfg_q   <= `TDMTX_RST_VS_SLOT;
      is_cfg_q   <= `TDMTX_RST_IS_SLOT;
      pd_cfg_q   <= `TDMTX_RST_PD_SLOT;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        `TDMTX_ADDR_LINE_FMT: line_fmt_q <= reg_wr_data;
        `TDMTX_ADDR_VS_SLOT:  vs_cfg_q   <= reg_wr_data;
        `TDMTX_ADDR_IS_SLOT:  is_cfg_q   <= reg_wr_data;
        `TDMTX_ADDR_PD_SLOT:  pd_cfg_q   <= reg_wr_data;
        default:              line_fmt_q <= line_fmt_q;
      endcase
    end
  end

  // Read data is registered one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rd_data <= 8'h00;
    else if (reg_rd_en)
    begin
      case (reg_addr)
        `TDMTX_ADDR_LINE_FMT: reg_rd_data <= line_fmt_q;
        `TDMTX_ADDR_VS_SLOT:  reg_rd_data <= vs_cfg_q;
        `TDMTX_ADDR_IS_SLOT:  reg_rd_data <= is_cfg_q;
        `TDMTX_ADDR_PD_SLOT:  reg_rd_data <= pd_cfg_q;
        default:              reg_rd_data <= 8'h00;
      endcase
    end
  end

  logic       lsb_half;
  logic       keep_cfg;
  logic       keep_en;
  logic       fill_hiz;
  logic [2:0] offset;
  logic       edge_fall;
  assign lsb_half  = line_fmt_q[`TDMTX_BIT_LSB_HALF];
  assign keep_cfg  = line_fmt_q[`TDMTX_BIT_KEEP_CFG];
  assign keep_en   = line_fmt_q[`TDMTX_BIT_KEEP_EN];
  assign fill_hiz  = line_fmt_q[`TDMTX_BIT_FILL];
  assign offset    = line_fmt_q[`TDMTX_OFS_HI:`TDMTX_OFS_LO];
  assign edge_fall = line_fmt_q[`TDMTX_BIT_EDGE];

  logic [2:0] sck_q;
  logic [1:0] fs_q;

  // Pin synchronisers; sck_q[0] and fs_q[0] feed only the next stage.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sck_q <= 3'h0;
      fs_q  <= 2'h0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], serial_bit_clock};
      fs_q  <= {fs_q[0], frame_sync};
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic launch_stb;
  logic half_stb;
  assign sck_rise   = sck_q[1] & ~sck_q[2];
  assign sck_fall   = ~sck_q[1] & sck_q[2];
  assign launch_stb = edge_fall ? sck_fall : sck_rise;
  assign half_stb   = edge_fall ? sck_rise : sck_fall;

  logic             fs_prev_q;
  logic             framed_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             frame_start;
  assign frame_start = sck_rise & fs_q[1] & ~fs_prev_q;

  // Bit-cycle counter within the frame, restarted by frame sync and saturating at the top.
  always_comb
  begin
    cnt_d = cnt_q;
    if (frame_start)
      cnt_d = '0;
    else if (sck_rise && cnt_q != {CNT_W{1'b1}})
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q     <= '0;
      fs_prev_q <= 1'b0;
      framed_q  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      if (sck_rise)
        fs_prev_q <= fs_q[1];
      if (frame_start)
        framed_q <= 1'b1;
    end
  end

  logic [WORD_BITS-1:0] vs_word_q;
  logic [WORD_BITS-1:0] is_word_q;
  logic [WORD_BITS-1:0] pd_word_q;

  // Words are captured once per frame so a slot never mixes two samples.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vs_word_q <= '0;
      is_word_q <= '0;
      pd_word_q <= '0;
    end
    else if (frame_start)
    begin
      vs_word_q <= voltage_sense_word;
      is_word_q <= current_sense_word;
      pd_word_q <= pulse_density_word;
    end
  end
  assign sample_taken = frame_start;
  // A rising launch on the frame-start edge already needs the new words.
  wire logic [WORD_BITS-1:0] vs_now = frame_start ? voltage_sense_word : vs_word_q;
  wire logic [WORD_BITS-1:0] is_now = frame_start ? current_sense_word : is_word_q;
  wire logic [WORD_BITS-1:0] pd_now = frame_start ? pulse_density_word : pd_word_q;

  // Locate the bit cycle that a launch edge opens; a rising launch uses the new count.
  logic [CNT_W-1:0]          bit_cnt;
  logic [CNT_W-1:0]          pos;
  logic [CNT_W-SLOT_LOG-1:0] slot_num;
  logic [SLOT_LOG-1:0]       bit_num;
  logic                      in_frame;
  logic                      in_word;
  tdmtx_src_t                src_hit;
  logic                      bit_val;
  assign bit_cnt  = sck_rise ? cnt_d : cnt_q;
  assign in_frame = (framed_q || frame_start) && (bit_cnt >= CNT_W'(offset));
  assign pos      = bit_cnt - CNT_W'(offset);
  assign slot_num = pos[CNT_W-1:SLOT_LOG];
  assign bit_num  = pos[SLOT_LOG-1:0];
  assign in_word  = in_frame && (32'(bit_num) < WORD_BITS);

  // Enabled slot match; on a clash current sense wins, then voltage, then PDM.
  always_comb
  begin
    src_hit = TDMTX_SRC_NONE;
    bit_val = 1'b0;
    if (in_word)
    begin
      if (is_cfg_q[`TDMTX_BIT_SEND_EN] && slot_num == (CNT_W-SLOT_LOG)'(is_cfg_q[5:0]))
      begin
        src_hit = TDMTX_SRC_IS;
        bit_val = is_now[WORD_BITS-1-32'(bit_num)];
      end
      else if (vs_cfg_q[`TDMTX_BIT_SEND_EN] && slot_num == (CNT_W-SLOT_LOG)'(vs_cfg_q[5:0]))
      begin
        src_hit = TDMTX_SRC_VS;
        bit_val = vs_now[WORD_BITS-1-32'(bit_num)];
      end
      else if (pd_cfg_q[`TDMTX_BIT_SEND_EN] && slot_num == (CNT_W-SLOT_LOG)'(pd_cfg_q[5:0]))
      begin
        src_hit = TDMTX_SRC_PD;
        bit_val = pd_now[WORD_BITS-1-32'(bit_num)];
      end
    end
  end

  tdmtx_line_t line_q;
  tdmtx_src_t  src_q;
  logic        last_q;
  logic        hold_q;
  logic        sdo_q;
  logic        oe_n_q;

  // Pin driver: data on launch edges, early release of the last bit on the half edge.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      line_q <= TDMTX_LN_FILL;
      src_q  <= TDMTX_SRC_NONE;
      last_q <= 1'b0;
      hold_q <= 1'b0;
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (launch_stb)
    begin
      src_q <= src_hit;
      if (src_hit != TDMTX_SRC_NONE)
      begin
        line_q <= TDMTX_LN_DATA;
        sdo_q  <= bit_val;
        oe_n_q <= 1'b0;
        last_q <= (32'(bit_num) == WORD_BITS - 1);
      end
      else if (line_q == TDMTX_LN_KEEP && keep_en && (keep_cfg || hold_q))
      begin
        hold_q <= 1'b0;
        last_q <= 1'b0;
      end
      else
      begin
        line_q <= TDMTX_LN_FILL;
        last_q <= 1'b0;
        sdo_q  <= 1'b0;
        oe_n_q <= fill_hiz;
      end
    end
    else if (half_stb && last_q && (lsb_half || keep_en))
    begin
      // Driver lets go mid-cycle; the keeper, if on, holds the last level.
      line_q <= keep_en ? TDMTX_LN_KEEP : TDMTX_LN_FILL;
      hold_q <= 1'b1;
      last_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
  end

  assign serial_data_output      = sdo_q;
  assign serial_data_output_oe_n = oe_n_q;
  assign serial_data_keeper_on   = (line_q == TDMTX_LN_KEEP);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence lsb_release_s;
    half_stb && last_q && (lsb_half || keep_en);
  endsequence
  sequence lsb_full_s;
    half_stb && last_q && !lsb_half && !keep_en;
  endsequence

  lsb_full_drive_a: assert property (lsb_full_s |=> !oe_n_q)
    else $error("last bit released early");
  lsb_half_drive_a: assert property (lsb_release_s |=> oe_n_q)
    else $error("last bit not released at half cycle");
  keeper_takes_a: assert property ((lsb_release_s and keep_en) |=> serial_data_keeper_on)
    else $error("keeper not active after last bit");
  keeper_off_a: assert property (launch_stb && !keep_en |=> !serial_data_keeper_on)
    else $error("keeper active while disabled");
  fill_level_a: assert property (launch_stb && src_hit == TDMTX_SRC_NONE
                                 && line_q == TDMTX_LN_FILL |=> oe_n_q == fill_hiz && !sdo_q)
    else $error("unused bit cycle not filled");
  launch_edge_a: assert property ($fell(oe_n_q) |-> $past(edge_fall ? sck_fall : sck_rise))
    else $error("data launched on wrong edge");
  voltage_gate_a: assert property (launch_stb && src_hit == TDMTX_SRC_VS |-> vs_cfg_q[6]
                                   && slot_num == (CNT_W-SLOT_LOG)'(vs_cfg_q[5:0]))
    else $error("voltage sense sent while disabled or off slot");
  current_gate_a: assert property (launch_stb && src_hit == TDMTX_SRC_IS |-> is_cfg_q[6]
                                   && slot_num == (CNT_W-SLOT_LOG)'(is_cfg_q[5:0]))
    else $error("current sense sent while disabled or off slot");
  pdm_gate_a: assert property (launch_stb && src_hit == TDMTX_SRC_PD |-> pd_cfg_q[6])
    else $error("PDM word sent while disabled");
  frame_offset_a: assert property (frame_start |=> cnt_q == '0 && in_frame == (offset == 3'h0))
    else $error("slot 0 not delayed by offset");
  data_slot_a: assert property (line_q == TDMTX_LN_DATA |-> src_q != TDMTX_SRC_NONE)
    else $error("data driven outside enabled slot");

endmodule

`default_nettype wire
